// >>> spl_port_map.vh
// spl_port_map.vh: constants for the serial peripheral pin-level port
// assumes inclusion by bare name from the design files of this block
`ifndef SPL_PORT_MAP_VH
`define SPL_PORT_MAP_VH

// pin index within the 4-bit shared pin group
`define SPL_PIN_MOSI 2
`define SPL_PIN_SCK 0
`define SPL_PIN_MISO 1
`define SPL_PIN_SEL 3

// reset values: serial function on all four pins, gpio all inputs
`define SPL_FUNC_RST 4'h0
`define SPL_GPIO_DIR_RST 4'h0
`define SPL_GPIO_OUT_RST 4'h0

// synchroniser reset levels: select idles high, the other pins low
`define SPL_PIN_RST 4'h8

// default frame length and shift clock half-period in core cycles
`define SPL_FRAME_BITS 8
`define SPL_HALF_PERIOD_CYC 4

`endif

// >>> spl_sync2.v
// spl_sync2.v: two-flop synchroniser for pin inputs
// assumes a single destination clock; first stage read only by the second
`timescale 1ns/100ps
`default_nettype none

module spl_sync2 #(
   parameter W = 4,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);

   reg [W-1:0] meta_q;

   // reset to the idle pin levels; the chain refills two edges after release
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end else if (i_ce) begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule // spl_sync2

`default_nettype wire

// >>> spl_port.v
// spl_port.v: pin-level serial peripheral port, master or slave role,
// with each of the four pins sharable with general-purpose i/o.
// assumes pins resolved by the bench from out/oe; user side on i_core_clk.
// Contract
// - master samples miso as input; slave drives miso as output
// - unselected slave releases miso so other slaves may drive it
// - master puts mosi bit half a clock period before capture edge
// - master drives serial clock out, clocking the attached slaves
// - slave takes serial clock as input and shifts data on it
// - master uses select input to arbitrate among several masters
// - slave is addressed only while the external master drives select
// - after reset all four pins come up in serial function; here pin function follows the i_gpio_func input, which reset does not touch
// - each pin can instead be gpio with individually programmed direction
// - while reset is applied all four pins are inputs
`timescale 1ns/100ps
`default_nettype none
`include "spl_port_map.vh"

module spl_port #(
   parameter NBITS = `SPL_FRAME_BITS,
   parameter HALF = `SPL_HALF_PERIOD_CYC
) (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire i_master,
   input wire [3:0] i_gpio_func,
   input wire [3:0] i_gpio_dir,
   input wire [3:0] i_gpio_out,
   output reg [3:0] o_gpio_in,
   input wire [3:0] i_port_e_in,
   output reg [3:0] o_port_e_out,
   output reg [3:0] o_port_e_oe,
   input wire i_tx_valid,
   input wire [NBITS-1:0] i_tx_data,
   output reg o_tx_ready,
   output reg o_rx_valid,
   output reg [NBITS-1:0] o_rx_data,
   output reg o_busy,
   output reg o_mode_fault,
   input wire i_fault_clr
);

   localparam ST_IDLE = 2'd0;
   localparam ST_LEAD = 2'd1;
   localparam ST_HIGH = 2'd2;
   localparam ST_LOW = 2'd3;
   localparam CW = 8;
   localparam BW = 5;

   wire [3:0] pin_s;
   reg [1:0] st_q;
   reg [CW-1:0] cnt_q;
   reg [BW-1:0] bit_q;
   reg [NBITS-1:0] sh_q;
   reg sck_q;
   reg sck_prev_q;
   reg s_mosi_q;
   wire sck_in;
   wire sel_n;
   wire cnt_done;
   wire sck_rise;
   wire sck_fall;
   wire slave_sel;
   wire [3:0] ser_oe;
   wire [3:0] ser_out;

   // every pin is asynchronous to the core clock; the chain resets to the
   // idle pin levels, else a master would read select low after reset
   // and flag a contention that never happened
   spl_sync2 #(.W(4), .RST_VAL(`SPL_PIN_RST)) u_sync (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_async(i_port_e_in),
      .o_sync(pin_s)
   );

   assign sck_in = pin_s[`SPL_PIN_SCK];
   assign sel_n = pin_s[`SPL_PIN_SEL]; // active low
   assign cnt_done = (cnt_q == HALF[CW-1:0] - 8'h01);
   assign sck_rise = ~sck_prev_q & sck_in;
   assign sck_fall = sck_prev_q & ~sck_in;
   assign slave_sel = ~i_master & ~sel_n;

   // serial drive per pin: master drives clock and mosi, slave drives miso
   assign ser_oe[`SPL_PIN_SCK] = i_master & ~o_mode_fault;
   assign ser_oe[`SPL_PIN_MOSI] = i_master & ~o_mode_fault;
   assign ser_oe[`SPL_PIN_MISO] = slave_sel;
   assign ser_oe[`SPL_PIN_SEL] = 1'b0; // select is always an input
   assign ser_out[`SPL_PIN_SCK] = sck_q;
   assign ser_out[`SPL_PIN_MOSI] = sh_q[NBITS-1];
   assign ser_out[`SPL_PIN_MISO] = s_mosi_q;
   assign ser_out[`SPL_PIN_SEL] = 1'b0;

   // pin mux registered so outputs come straight from flops
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_port_e_oe <= 4'h0;
         o_port_e_out <= 4'h0;
         o_gpio_in <= 4'h0;
      end else if (i_ce) begin
         o_port_e_oe <= (i_gpio_func & i_gpio_dir) | (~i_gpio_func & ser_oe);
         o_port_e_out <= (i_gpio_func & i_gpio_out) | (~i_gpio_func & ser_out);
         o_gpio_in <= pin_s;
      end
   end

   // edge history of the synchronised clock; resets to its idle low level
   // so no false edge follows reset
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         sck_prev_q <= 1'b0;
      end else if (i_ce) begin
         sck_prev_q <= sck_in;
      end
   end

   // mode fault is sticky; a new contention wins over a clear
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_mode_fault <= 1'b0;
      end else if (i_ce) begin
         if (i_master & ~i_gpio_func[`SPL_PIN_SEL] & ~sel_n) begin
            o_mode_fault <= 1'b1;
         end else if (i_fault_clr) begin
            o_mode_fault <= 1'b0;
         end
      end
   end

   // master: mode 0, data set half a period ahead of each rising edge;
   // slave: capture on rising, shift out on falling of the external clock
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_q <= ST_IDLE;
         cnt_q <= 8'h00;
         bit_q <= 5'h00;
         sh_q <= {NBITS{1'b0}};
         sck_q <= 1'b0;
         s_mosi_q <= 1'b0;
         o_tx_ready <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_data <= {NBITS{1'b0}};
         o_busy <= 1'b0;
      end else if (i_ce) begin
         o_rx_valid <= 1'b0;
         o_tx_ready <= 1'b0;
         if (i_master) begin
            case (st_q)
               ST_IDLE: begin
                  sck_q <= 1'b0;
                  o_tx_ready <= ~o_mode_fault & ~i_tx_valid;
                  if (i_tx_valid & ~o_mode_fault & ~o_tx_ready) begin
                     sh_q <= i_tx_data; // first bit presented now
                     bit_q <= 5'h00;
                     cnt_q <= 8'h00;
                     o_busy <= 1'b1;
                     st_q <= ST_LEAD;
                  end
               end
               ST_LEAD, ST_LOW: begin
                  // low half: bit already on mosi for one half period
                  cnt_q <= cnt_done ? 8'h00 : cnt_q + 8'h01;
                  if (cnt_done) begin
                     sck_q <= 1'b1;
                     st_q <= ST_HIGH;
                  end
               end
               ST_HIGH: begin
                  cnt_q <= cnt_done ? 8'h00 : cnt_q + 8'h01;
                  if (cnt_done) begin
                     sck_q <= 1'b0;
                     sh_q <= {sh_q[NBITS-2:0], pin_s[`SPL_PIN_MISO]};
                     bit_q <= bit_q + 5'h01;
                     if (bit_q == NBITS[BW-1:0] - 5'h01) begin
                        o_rx_data <= {sh_q[NBITS-2:0], pin_s[`SPL_PIN_MISO]};
                        o_rx_valid <= 1'b1;
                        o_busy <= 1'b0;
                        st_q <= ST_IDLE;
                     end else begin
                        st_q <= ST_LOW;
                     end
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
            if (o_mode_fault) begin
               st_q <= ST_IDLE;
               sck_q <= 1'b0;
               o_busy <= 1'b0;
            end
         end else begin
            st_q <= ST_IDLE;
            sck_q <= 1'b0;
            if (~slave_sel) begin
               bit_q <= 5'h00;
               o_busy <= 1'b0;
               o_tx_ready <= 1'b1;
               if (i_tx_valid) begin
                  sh_q <= i_tx_data;
                  s_mosi_q <= i_tx_data[NBITS-1];
               end
            end else begin
               o_busy <= 1'b1;
               if (sck_rise) begin
                  sh_q <= {sh_q[NBITS-2:0], pin_s[`SPL_PIN_MOSI]};
                  bit_q <= bit_q + 5'h01;
                  if (bit_q == NBITS[BW-1:0] - 5'h01) begin
                     o_rx_data <= {sh_q[NBITS-2:0], pin_s[`SPL_PIN_MOSI]};
                     o_rx_valid <= 1'b1;
                     bit_q <= 5'h00;
                  end
               end else if (sck_fall) begin
                  s_mosi_q <= sh_q[NBITS-1];
               end
            end
         end
      end
   end

endmodule // spl_port

`default_nettype wire

// >>> spl_port_checker.sv
// spl_port_checker.sv: assertions on the pins of spl_port
// assumes role and pin function change only while reset is high
`timescale 1ns/100ps
`default_nettype none
module spl_port_checker #(
   parameter NBITS = 8,
   parameter HALF = 4
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_master,
   input wire logic [3:0] i_gpio_func,
   input wire logic [3:0] i_gpio_dir,
   input wire logic [3:0] i_port_e_in,
   input wire logic [3:0] o_port_e_out,
   input wire logic [3:0] o_port_e_oe,
   input wire logic o_busy,
   input wire logic o_mode_fault
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   reset_quiet_a: assert property (disable iff (1'b0) i_sys_rst |=> o_port_e_oe == 4'h0)
      else $error("pin driven in reset");
   master_miso_in_a: assert property (i_master && !i_gpio_func[1] |-> !o_port_e_oe[1])
      else $error("master drives miso");
   slave_sck_in_a: assert property (!i_master && !i_gpio_func[0] |-> !o_port_e_oe[0])
      else $error("slave drives sck");
   idle_miso_off_a: assert property ((!i_master && !i_gpio_func[1] && i_port_e_in[3])[*4]
      |-> !o_port_e_oe[1]) else $error("unselected slave drives miso");
   mosi_lead_a: assert property ($rose(o_port_e_out[0]) && o_port_e_oe[0] &&
      !i_gpio_func[0] && !i_gpio_func[2] |->
      $past(o_port_e_out[2], HALF - 1) == o_port_e_out[2]) else $error("mosi moved before sck");
   master_sck_out_a: assert property (i_master && !i_gpio_func[0] && o_busy && $past(o_busy)
      && !o_mode_fault |-> o_port_e_oe[0]) else $error("master sck not driven");
   select_contention_a: assert property (i_master && !i_gpio_func[3] && o_busy &&
      !i_port_e_in[3]
      |-> ##[1:5] o_mode_fault) else $error("contention not flagged");
   fault_quiet_a: assert property (o_mode_fault && $past(o_mode_fault) && i_gpio_func == 4'h0
      |-> (o_port_e_oe & 4'h5) == 4'h0) else $error("faulted master still drives");
   gpio_dir_a: assert property ((i_gpio_func == 4'hf && $stable(i_gpio_dir))[*4]
      |-> o_port_e_oe == i_gpio_dir) else $error("gpio direction wrong");
endmodule // spl_port_checker
bind spl_port spl_port_checker #(.NBITS(NBITS), .HALF(HALF)) spl_port_checker_i (
   .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_master(i_master),
   .i_gpio_func(i_gpio_func), .i_gpio_dir(i_gpio_dir), .i_port_e_in(i_port_e_in),
   .o_port_e_out(o_port_e_out), .o_port_e_oe(o_port_e_oe), .o_busy(o_busy),
   .o_mode_fault(o_mode_fault));
`default_nettype wire

// >>> spl_slave_model.sv
// spl_slave_model.sv: external mode-0 slave facing the port in master role
// assumes resolved pin levels from the bench
`timescale 1ns/100ps
`default_nettype none
module spl_slave_model (
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_sel_n,
   input wire logic [7:0] i_word,
   output logic o_miso,
   output logic o_miso_oe,
   output logic [7:0] o_got
);
   logic [7:0] sh_q;
   // load on select, capture on rise, shift on fall
   always @(negedge i_sel_n) sh_q <= i_word;
   always @(posedge i_sck) if (!i_sel_n) o_got <= {o_got[6:0], i_mosi};
   always @(negedge i_sck) if (!i_sel_n) sh_q <= {sh_q[6:0], 1'b0};
   // drives only while selected so other slaves can share miso
   assign o_miso = sh_q[7];
   assign o_miso_oe = !i_sel_n;
endmodule // spl_slave_model
`default_nettype wire

// >>> tb_spl_port.sv
// tb_spl_port.sv: self-checking bench for spl_port in both roles
// assumes the slave model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_spl_port;
   logic clk = 0, rst = 1, mst = 1, tv = 0, fclr = 0, tog = 0, sel_n = 1, m_oe = 0, m_sck = 0;
   logic m_mosi = 0, p_sel = 1, s_miso, s_oe, rxv, rdy, busy, flt;
   logic [3:0] func = 4'h0, dir = 4'h0, gout = 4'h0, pin, gin, po, oe;
   logic [7:0] td = 8'h00, p_word = 8'h00, p_got, rxd;
   logic [7:0] exp_q[$];
   logic [31:0] r1, r2;
   int err_count = 0, n_compared = 0;
   always #10 clk = ~clk;
   // undriven data lines wander so a stale level never passes for data
   always @(posedge clk) tog <= ~tog;
   // sck idles low when nobody drives it, as if pulled down
   assign pin[0] = oe[0] ? po[0] : m_oe ? m_sck : 1'b0;
   assign pin[1] = oe[1] ? po[1] : s_oe ? s_miso : tog;
   assign pin[2] = oe[2] ? po[2] : m_oe ? m_mosi : tog;
   assign pin[3] = oe[3] ? po[3] : sel_n;
   spl_port #(.NBITS(8), .HALF(4)) spl_port_i (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
      .i_master(mst), .i_gpio_func(func), .i_gpio_dir(dir), .i_gpio_out(gout), .o_gpio_in(gin),
      .i_port_e_in(pin), .o_port_e_out(po), .o_port_e_oe(oe), .i_tx_valid(tv), .i_tx_data(td),
      .o_tx_ready(rdy), .o_rx_valid(rxv), .o_rx_data(rxd), .o_busy(busy), .o_mode_fault(flt),
      .i_fault_clr(fclr));
   spl_slave_model spl_slave_model_i (.i_sck(pin[0]), .i_mosi(pin[2]), .i_sel_n(p_sel),
      .i_word(p_word), .o_miso(s_miso), .o_miso_oe(s_oe), .o_got(p_got));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic reset_in(input logic m, input logic [3:0] f);
      rst = 1;
      mst = m;
      func = f;
      repeat (5) @(negedge clk);
      chk("oe_in_reset", 8'h00, {4'h0, oe});
      rst = 0;
      repeat (6) @(negedge clk);
   endtask
   // port as master against the slave model
   task automatic mxfer(input logic [7:0] w, input logic [7:0] r);
      int n;
      p_word = r;
      p_sel = 0;
      exp_q.push_back(r);
      td = w;
      tv = 1;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin @(negedge clk); n++; end
      tv = 0;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin @(negedge clk); n++; end
      repeat (4) @(negedge clk);
      p_sel = 1;
      @(negedge clk);
      chk("mosi_word", w, p_got);
   endtask
   // bench as master, 160 ns sck off the core clock phase
   task automatic sxfer(input logic [7:0] w, input logic [7:0] r);
      logic [7:0] g;
      td = w;
      tv = 1;
      exp_q.push_back(r);
      #203 sel_n = 0;
      m_oe = 1;
      #100;
      for (int k = 7; k >= 0; k--) begin
         m_mosi = r[k];
         #80 m_sck = 1;
         #80 g[k] = pin[1];
         m_sck = 0;
      end
      #100 sel_n = 1;
      m_oe = 0;
      @(negedge clk);
      tv = 0;
      @(negedge clk);
      chk("miso_word", w, g);
   endtask
   // every received word is matched with the oldest expectation
   always @(negedge clk) if (rxv === 1'b1) begin
      if (exp_q.size() == 0) chk("rx_extra", 8'h00, 8'h01);
      else chk("rx_data", exp_q.pop_front(), rxd);
   end
   // whole run needs well under 5000 core cycles
   initial begin #400000; err_count++; print_verdict; end
   initial begin
      void'($urandom(32'h4e1a_0730));
      reset_in(1'b1, 4'h0);
      repeat (3) begin r1 = $urandom; r2 = $urandom; mxfer(r1[7:0], r2[7:0]); end
      tv = 1;
      repeat (2) @(negedge clk);
      tv = 0;
      repeat (10) @(negedge clk);
      sel_n = 0;
      repeat (8) @(negedge clk);
      chk("fault", 8'h01, {7'h0, flt});
      chk("faulted_oe", 8'h00, {4'h0, oe & 4'h5});
      chk("faulted_busy", 8'h00, {7'h0, busy});
      chk("faulted_ready", 8'h00, {7'h0, rdy});
      sel_n = 1;
      repeat (4) @(negedge clk);
      fclr = 1;
      @(negedge clk);
      fclr = 0;
      repeat (2) @(negedge clk);
      chk("fault_clr", 8'h00, {7'h0, flt});
      reset_in(1'b0, 4'h0);
      chk("slave_idle_oe", 8'h00, {4'h0, oe});
      repeat (3) begin r1 = $urandom; r2 = $urandom; sxfer(r1[7:0], r2[7:0]); end
      r1 = $urandom;
      dir = r1[3:0];
      gout = r1[7:4];
      reset_in(1'b0, 4'hf);
      chk("gpio_oe", {4'h0, r1[3:0]}, {4'h0, oe});
      chk("gpio_in", {4'h0, r1[7:4] & r1[3:0]}, {4'h0, gin & r1[3:0]});
      print_verdict;
   end
endmodule // tb_spl_port
`default_nettype wire
